// ---- hw/ebr_ctrl.sv ----
// Purpose: external bus cycle sequencer with ready-controlled waitstates
// Assumes: one 200 MHz clock, AHB-Lite register access, ready pin asynchronous
// Notes:   one phase time unit equals one period of reference_clock_out
`default_nettype none
module ebr_ctrl
    import ebr_pkg::*;
(
    input  wire logic                sys_clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                hsel_in,
    input  wire logic [31:0]         haddr_in,
    input  wire logic [1:0]          htrans_in,
    input  wire logic                hwrite_in,
    input  wire logic [2:0]          hsize_in,
    input  wire logic [31:0]         hwdata_in,
    input  wire logic                hready_in,
    output logic      [31:0]         hrdata_out,
    output logic                     hreadyout_out,
    output logic                     hresp_out,
    output logic                     reference_clock_out,
    output logic      [ADDR_W-1:0]   addr_out,
    output logic                     cs_n_out,
    output logic                     ale_out,
    output logic                     rd_n_out,
    output logic                     wr_n_out,
    input  wire logic [DATA_W-1:0]   data_in,
    output logic      [DATA_W-1:0]   data_out,
    output logic                     data_oe_out,
    input  wire logic                ready_in
);
    // phase length in units for a given phase
    function automatic logic [CNT_W-1:0] len_of(input ebr_phase_t ph, input ebr_cfg_t c);
        case (ph)
            PH_AB:   len_of = CNT_W'(c.ab_len_m1) + CNT_ONE;
            PH_C:    len_of = CNT_W'(c.c_len);
            PH_D:    len_of = CNT_W'(c.d_len);
            PH_E:    len_of = CNT_W'(c.e_len_m1) + CNT_ONE;
            PH_F:    len_of = CNT_W'(c.f_len);
            default: len_of = CNT_ONE;
        endcase
    endfunction

    // following phase, skipping any of zero length
    function automatic ebr_phase_t next_of(input ebr_phase_t ph, input ebr_cfg_t c);
        case (ph)
            PH_AB:   next_of = (c.c_len != '0) ? PH_C : (c.d_len ? PH_D : PH_E);
            PH_C:    next_of = c.d_len ? PH_D : PH_E;
            PH_D:    next_of = PH_E;
            PH_E:    next_of = (c.f_len != '0) ? PH_F : PH_IDLE;
            default: next_of = PH_IDLE;
        endcase
    endfunction

    ebr_cfg_t          cfg_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic              done_reg;
    logic              pend_reg;
    logic              pend_wr_reg;
    logic              cyc_wr_reg;
    logic [WS_W-1:0]   ws_reg;
    logic [4:0]        div_reg;
    logic [CNT_W-1:0]  cnt_reg;
    ebr_phase_t        ph_reg;
    ebr_phase_t        ph_next;
    ebr_bus_t          bus_reg;
    ebr_bus_t          bus_next;
    logic              ahb_wr_reg;
    logic [7:0]        ahb_addr_reg;
    logic              async1_reg;
    logic              async2_reg;
    logic              rdy_pin;
    logic [DATA_W-1:0] data_sync;

    // every pin input passes the agreement synchroniser
    ebr_sync3 #(.W(DATA_W + 1)) u_pin_sync (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   ({ready_in, data_in}),
        .sync_out   ({rdy_pin, data_sync})
    );

    // ahb decode and read mux
    wire        ahb_take  = hsel_in & htrans_in[1] & hready_in;
    wire        wr_ctrl   = ahb_wr_reg & (ahb_addr_reg == OFF_CTRL);
    wire        wr_addr   = ahb_wr_reg & (ahb_addr_reg == OFF_ADDR);
    wire        wr_wdata  = ahb_wr_reg & (ahb_addr_reg == OFF_WDATA);
    wire        wr_cmd    = ahb_wr_reg & (ahb_addr_reg == OFF_CMD);
    wire        wr_status = ahb_wr_reg & (ahb_addr_reg == OFF_STATUS);
    wire        busy      = pend_reg | (ph_reg != PH_IDLE);
    wire        go        = wr_cmd & hwdata_in[CMD_GO] & ~busy;
    wire [7:0]  rd_off    = {haddr_in[7:2], 2'b00};
    wire [31:0] rd_word   =
        (rd_off == OFF_CTRL)   ? 32'(cfg_reg) :
        (rd_off == OFF_ADDR)   ? 32'(addr_reg) :
        (rd_off == OFF_WDATA)  ? 32'(wdata_reg) :
        (rd_off == OFF_STATUS) ? ({16'h0000, ws_reg, 6'h00, done_reg, busy}) :
        (rd_off == OFF_RDATA)  ? 32'(rdata_reg) : 32'h0000_0000;

    // zero-wait slave: reads answered from the address phase
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ahb_wr_reg    <= 1'b0;
            ahb_addr_reg  <= 8'h00;
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else begin
            ahb_wr_reg    <= ahb_take & hwrite_in;
            ahb_addr_reg  <= rd_off;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            if (ahb_take & ~hwrite_in) begin
                hrdata_out <= rd_word;
            end
        end
    end

    // unit boundary strobe, declared early since the register block uses it
    wire tick    = (div_reg == TU_LAST);

    // software registers; done set wins over a clear in the same cycle
    wire cyc_end = tick & (ph_reg != PH_IDLE) & (ph_next == PH_IDLE);
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_reg   <= ebr_cfg_t'(CTRL_RST);
            addr_reg  <= '0;
            wdata_reg <= '0;
            done_reg  <= 1'b0;
            pend_reg  <= 1'b0;
            pend_wr_reg <= 1'b0;
        end else begin
            if (wr_ctrl) cfg_reg <= ebr_cfg_t'(hwdata_in[CTRL_W-1:0]);
            if (wr_addr) addr_reg <= hwdata_in[ADDR_W-1:0];
            if (wr_wdata) wdata_reg <= hwdata_in[DATA_W-1:0];
            if (cyc_end) done_reg <= 1'b1;
            else if (wr_status & hwdata_in[ST_DONE]) done_reg <= 1'b0;
            if (go) begin
                pend_reg    <= 1'b1;
                pend_wr_reg <= hwdata_in[CMD_WRITE];
            end else if (tick) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // reference clock divider; tick marks each unit boundary
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_reg             <= 5'h00;
            reference_clock_out <= 1'b0;
        end else begin
            div_reg             <= tick ? 5'h00 : div_reg + 5'h01;
            reference_clock_out <= (tick || div_reg < TU_HALF - 5'h01);
        end
    end

    // ready: polarity first, then optional two-flop async stage
    wire rdy_act = rdy_pin ^ ~cfg_reg.rdy_pol;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            async1_reg <= 1'b0;
            async2_reg <= 1'b0;
        end else begin
            async1_reg <= rdy_act;
            async2_reg <= async1_reg;
        end
    end

    // access phase sampling: mandatory units, async adds one unit
    wire [CNT_W-1:0] units   = (cnt_reg == CNT_MAX) ? CNT_MAX : cnt_reg + CNT_ONE;
    wire [CNT_W-1:0] ph_len  = len_of(ph_reg, cfg_reg);
    wire [CNT_W-1:0] mand    = ph_len + CNT_W'(cfg_reg.rdy_async);
    wire             rdy_val = cfg_reg.rdy_async ? async2_reg : rdy_act;
    wire             in_e    = (ph_reg == PH_E);
    wire             sample  = tick & in_e & cfg_reg.rdy_en & (units >= mand);
    wire             ph_done = in_e ? (cfg_reg.rdy_en ? (sample & rdy_val)
                                                      : (units >= ph_len))
                                    : (units >= ph_len);
    // only a not-ready sample point counts, mandatory units are not waitstates
    wire             is_ws   = sample & ~rdy_val;

    // phase sequencing, all moves on a unit boundary
    always_comb begin
        ph_next = ph_reg;
        if (tick) begin
            case (ph_reg)
                PH_IDLE: ph_next = pend_reg ? PH_AB : PH_IDLE;
                PH_AB, PH_C, PH_D, PH_E, PH_F: begin
                    if (ph_done) ph_next = next_of(ph_reg, cfg_reg);
                end
                default: ph_next = PH_IDLE;
            endcase
        end
    end

    // pin values follow the next phase so they flip with the state
    wire cyc_wr = (ph_reg == PH_IDLE) ? pend_wr_reg : cyc_wr_reg;
    always_comb begin
        bus_next         = BUS_IDLE;
        bus_next.addr    = bus_reg.addr;
        bus_next.wdata   = bus_reg.wdata;
        if (ph_next != PH_IDLE) begin
            bus_next.cs_n    = 1'b0;
            bus_next.addr    = addr_reg;
            bus_next.wdata   = wdata_reg;
            bus_next.ale     = (ph_next == PH_AB);
            bus_next.data_oe = cyc_wr & (ph_next == PH_D || ph_next == PH_E || ph_next == PH_F);
            bus_next.rd_n    = ~(~cyc_wr & (ph_next == PH_E));
            bus_next.wr_n    = ~(cyc_wr & (ph_next == PH_E));
        end
    end

    // capture read data on the edge that raises the read strobe
    wire cap = tick & in_e & (ph_next != PH_E) & ~cyc_wr_reg;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ph_reg     <= PH_IDLE;
            cnt_reg    <= '0;
            cyc_wr_reg <= 1'b0;
            ws_reg     <= '0;
            rdata_reg  <= '0;
            bus_reg    <= BUS_IDLE;
        end else begin
            ph_reg  <= ph_next;
            bus_reg <= bus_next;
            if (tick) cnt_reg <= (ph_next != ph_reg) ? '0 : units;
            if (tick & (ph_reg == PH_IDLE) & pend_reg) begin
                cyc_wr_reg <= pend_wr_reg;
                ws_reg     <= '0;
            end
            if (is_ws && ws_reg != WS_MAX) ws_reg <= ws_reg + 8'h01;
            if (cap) rdata_reg <= data_sync;
        end
    end

    // outputs straight from the pin register
    assign addr_out    = bus_reg.addr;
    assign data_out    = bus_reg.wdata;
    assign data_oe_out = bus_reg.data_oe;
    assign cs_n_out    = bus_reg.cs_n;
    assign ale_out     = bus_reg.ale;
    assign rd_n_out    = bus_reg.rd_n;
    assign wr_n_out    = bus_reg.wr_n;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_STROBE_IN_ACCESS: assert property (!rd_n_out || !wr_n_out |-> ph_reg == PH_E)
        else $error("strobe active outside access phase");
    AST_CAPTURE_ON_RISE: assert property ($rose(rd_n_out) |-> rdata_reg == $past(data_sync))
        else $error("read data not captured at strobe rise");
    AST_DATA_HELD: assert property (!cap |=> $stable(rdata_reg))
        else $error("read data changed outside capture");
    AST_POLARITY: assert property (rdy_act == (cfg_reg.rdy_pol ? rdy_pin : ~rdy_pin))
        else $error("ready polarity wrong");
    AST_ASYNC_STAGE: assert property ($stable(cfg_reg.rdy_pol) [*3] |-> async2_reg == $past(rdy_act, 2))
        else $error("async stage not two flops");
    AST_ASYNC_LATE: assert property (sample && cfg_reg.rdy_async |-> units > ph_len)
        else $error("async sample point too early");
    AST_WAIT_INACTIVE: assert property (sample && !rdy_val |=> ph_reg == PH_E && !rd_n_out == !cyc_wr_reg)
        else $error("no waitstate on inactive ready");
    AST_END_ACTIVE: assert property (sample && rdy_val |=> ph_reg != PH_E)
        else $error("cycle not ended on active ready");
    AST_MANDATORY: assert property (tick && in_e && units < ph_len |=> ph_reg == PH_E)
        else $error("access ended before mandatory units");
    AST_PHASE_LEN: assert property (tick && in_e && !cfg_reg.rdy_en && units == ph_len |=> ph_reg != PH_E)
        else $error("access phase overran programmed length");
endmodule // ebr_ctrl
`default_nettype wire

// ---- hw/ebr_pkg.sv ----
// Purpose: shared constants and types for the external bus ready/wait controller
// Assumes: 200 MHz system clock, reference clock out derived by an even divider
// Notes:   register map is word aligned on an AHB-Lite slave
`default_nettype none
package ebr_pkg;
    // timing: reference clock period and the system clock period, both in ns
    localparam int unsigned SYS_PERIOD_NS = 5;
    localparam int unsigned REF_PERIOD_NS = 160;
    localparam int unsigned TU_DIV        = REF_PERIOD_NS / SYS_PERIOD_NS;
    localparam logic [4:0]  TU_LAST       = 5'(TU_DIV - 1);
    localparam logic [4:0]  TU_HALF       = 5'(TU_DIV / 2);

    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_ADDR   = 8'h04;
    localparam logic [7:0] OFF_WDATA  = 8'h08;
    localparam logic [7:0] OFF_CMD    = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_RDATA  = 8'h14;

    // field positions and widths
    localparam int unsigned CTRL_W     = 14;
    localparam int unsigned ADDR_W     = 24;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned CNT_W      = 6;
    localparam int unsigned WS_W       = 8;
    localparam int unsigned CMD_GO     = 0;
    localparam int unsigned CMD_WRITE  = 1;
    localparam int unsigned ST_BUSY    = 0;
    localparam int unsigned ST_DONE    = 1;
    localparam int unsigned ST_WS_LSB  = 8;

    // reset value: ready active high, all phases shortest, ready off
    localparam logic [CTRL_W-1:0] CTRL_RST = 14'h1000;
    localparam logic [CNT_W-1:0]  CNT_MAX  = 6'h3F;
    localparam logic [CNT_W-1:0]  CNT_ONE  = 6'h01;
    localparam logic [WS_W-1:0]   WS_MAX   = 8'hFF;

    // control register layout, low bit first from the bottom of the struct
    typedef struct packed {
        logic       rdy_async;
        logic       rdy_pol;
        logic       rdy_en;
        logic [1:0] f_len;
        logic [4:0] e_len_m1;
        logic       d_len;
        logic [1:0] c_len;
        logic       ab_len_m1;
    } ebr_cfg_t;

    // pin side outputs of the external bus
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              data_oe;
        logic              cs_n;
        logic              ale;
        logic              rd_n;
        logic              wr_n;
    } ebr_bus_t;

    localparam ebr_bus_t BUS_IDLE = '{addr: '0, wdata: '0, data_oe: 1'b0, cs_n: 1'b1,
                                      ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1};

    // bus cycle phases, one-hot
    typedef enum logic [5:0] {
        PH_IDLE = 6'h01,
        PH_AB   = 6'h02,
        PH_C    = 6'h04,
        PH_D    = 6'h08,
        PH_E    = 6'h10,
        PH_F    = 6'h20
    } ebr_phase_t;
endpackage : ebr_pkg
`default_nettype wire

// ---- hw/ebr_sync3.sv ----
// Purpose: three-flop input synchroniser with agreement filter
// Assumes: input is asynchronous to sys_clk_in
// Notes:   output changes only once stages two and three agree
`default_nettype none
module ebr_sync3 #(
    parameter int unsigned W = 1
) (
    input  wire logic         sys_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] q1_reg;
    logic [W-1:0] q2_reg;
    logic [W-1:0] q3_reg;

    // q1 feeds q2 only; per-bit agreement picks the settled value
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q1_reg   <= '0;
            q2_reg   <= '0;
            q3_reg   <= '0;
            sync_out <= '0;
        end else begin
            q1_reg   <= async_in;
            q2_reg   <= q1_reg;
            q3_reg   <= q2_reg;
            sync_out <= (q2_reg & q3_reg) | (sync_out & (q2_reg | q3_reg));
        end
    end
endmodule // ebr_sync3
`default_nettype wire

// ---- dv/ebr_mem_model.sv ----
// Purpose: behavioural external memory answering the bus with a ready handshake
// Assumes: strobes and address come straight from the controller pins
// Notes:   ready delay and hold are set per cycle by the bench
`default_nettype none
module ebr_mem_model
    import ebr_pkg::*;
(
    input  wire logic              ref_clk_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic              rd_n_in,
    input  wire logic              wr_n_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic              rdy_pol_in,
    input  var  int                wait_in,
    input  var  int                dly_in,
    input  var  int                hold_in,
    output logic      [DATA_W-1:0] rdata_out,
    output logic                   ready_out
);
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] last_reg;
    logic              ready_act;
    wire  logic        strobe;

    // released bus shows the inverse of the last word, so a late capture fails
    assign strobe    = rd_n_in & wr_n_in;
    assign rdata_out = !rd_n_in ? mem[addr_in[3:0]] : ~last_reg;
    assign ready_out = ready_act ? rdy_pol_in : !rdy_pol_in;

    initial begin
        ready_act = 1'b0;
        last_reg  = 16'h0000;
        foreach (mem[i]) mem[i] = 16'h0000;
    end

    // remember the word shown and store writes at strobe end
    always @(posedge rd_n_in) last_reg = mem[addr_in[3:0]];
    always @(posedge wr_n_in) begin
        if ($time > 0) mem[addr_in[3:0]] = wdata_in;
    end

    // ready after wait_in reference edges; a short settle skips the launch edge
    always @(negedge strobe) begin : rdy_gen
        int k;
        k = 0;
        #20;
        while (k < wait_in && !strobe) begin
            @(posedge ref_clk_in or posedge strobe);
            k++;
        end
        #(dly_in);
        if (!strobe) ready_act = 1'b1;
    end

    // hold keeps an async assertion for hold_in after the strobe ends, 110 ns in the bench, under one reference period
    always @(posedge strobe) begin
        #(hold_in);
        ready_act = 1'b0;
    end
endmodule // ebr_mem_model
`default_nettype wire

// ---- dv/tb_ebr_ctrl.sv ----
// Purpose: self-checking bench for the bus cycle and ready controller
// Assumes: single slave, hready fed back from hreadyout
// Notes:   phase lengths checked by counting sys cycles on the pins
`default_nettype none
module tb_ebr_ctrl
    import ebr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int tu = int'(TU_DIV);

    logic                    sys_clk, rst_n, hsel, hwrite, rdy_pol;
    logic [1:0]              htrans;
    logic [2:0]              hsize;
    logic [31:0]             haddr, hwdata;
    wire  logic [31:0]       hrdata;
    wire  logic              hready, hresp, ref_clk, cs_n, ale, rd_n, wr_n, data_oe, ready;
    wire  logic [ADDR_W-1:0] addr;
    wire  logic [DATA_W-1:0] dout, din;
    int                      wait_u, dly, hold, rd_c, wr_c, cs_c, ale_c, oe_c, ref_c;
    int                      bad_count = 0;
    int                      compares = 0;
    int                      cyc = 0;

    ebr_ctrl ebr_ctrl_i (
        .sys_clk_in(sys_clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .reference_clock_out(ref_clk), .addr_out(addr), .cs_n_out(cs_n), .ale_out(ale),
        .rd_n_out(rd_n), .wr_n_out(wr_n), .data_in(din), .data_out(dout),
        .data_oe_out(data_oe), .ready_in(ready)
    );

    ebr_mem_model ebr_mem_model_i (
        .ref_clk_in(ref_clk), .addr_in(addr), .rd_n_in(rd_n), .wr_n_in(wr_n),
        .wdata_in(dout), .rdy_pol_in(rdy_pol), .wait_in(wait_u), .dly_in(dly),
        .hold_in(hold), .rdata_out(din), .ready_out(ready)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // pin occupancy counters and the hang guard
    always @(posedge sys_clk) begin
        cyc++;
        rd_c  += int'(rd_n === 1'b0);
        wr_c  += int'(wr_n === 1'b0);
        cs_c  += int'(cs_n === 1'b0);
        ale_c += int'(ale === 1'b1);
        oe_c  += int'(data_oe === 1'b1);
        ref_c += int'(cs_n === 1'b0 && ref_clk === 1'b1);
        if (cyc == 40000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_count(input string name, input int exp, input int got);
        compares++;
        if (got != exp) begin
            bad_count++;
            $display("Error %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    // one single transfer; waits on hready instead of assuming a latency
    task automatic ahb(input logic wr, input logic [7:0] off, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, off};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask

    task automatic wr_reg(input logic [7:0] off, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, off, d, x);
    endtask

    task automatic rd_reg(input logic [7:0] off, output logic [31:0] d);
        ahb(1'b0, off, 32'h00000000, d);
    endtask

    function automatic logic [31:0] cfg(int ab, int c, int d, int e, int f, int en, int pol, int as_m);
        return 32'((ab - 1) | (c << 1) | (d << 3) | ((e - 1) << 4) | (f << 9) | (en << 11) | (pol << 12) |
                   (as_m << 13));
    endfunction

    // start a cycle, poll done, let cs settle, then clear the sticky flag
    task automatic run_cycle(input logic [31:0] cmd, output logic [31:0] st);
        int n;
        rd_c  = 0;
        wr_c  = 0;
        cs_c  = 0;
        ale_c = 0;
        oe_c  = 0;
        ref_c = 0;
        wr_reg(OFF_CMD, cmd);
        wr_reg(OFF_CMD, cmd ^ 32'h00000002); // second go lands while busy and must be dropped
        n  = 0;
        st = 32'h00000000;
        while (st[ST_DONE] !== 1'b1 && n < 2000) begin
            rd_reg(OFF_STATUS, st);
            n++;
        end
        n = 0;
        while (cs_n !== 1'b1 && n < 1000) begin
            @(posedge sys_clk);
            n++;
        end
        check_word("done", 32'h00000001, 32'(st[ST_DONE]));
        wr_reg(OFF_STATUS, 32'h00000002);
    endtask

    task automatic t_reset();
        logic [31:0] v;
        rd_reg(OFF_CTRL, v);
        check_word("ctrl", 32'(CTRL_RST), v);
        rd_reg(OFF_STATUS, v);
        check_word("status", 32'h00000000, v);
        wr_reg(8'h20, 32'hFFFFFFFF);
        rd_reg(8'h20, v);
        check_word("unmapped", 32'h00000000, v);
        check_word("hresp", 32'h00000000, 32'(hresp));
    endtask

    // all phases longer than minimum, ready off: write then read back
    task automatic t_write_read();
        logic [31:0] st, v;
        wait_u = 99;
        wr_reg(OFF_CTRL, cfg(2, 1, 1, 2, 1, 0, 1, 0));
        wr_reg(OFF_ADDR, 32'h00000123);
        wr_reg(OFF_WDATA, 32'h00005AC3);
        run_cycle(32'h00000003, st);
        check_count("wr_len", 2 * tu, wr_c);
        check_count("cs_len", 7 * tu, cs_c);
        check_count("ale_len", 2 * tu, ale_c);
        check_count("oe_len", 4 * tu, oe_c);
        check_count("ref_high", 7 * tu / 2, ref_c);
        check_word("addr", 32'h00000123, 32'(addr));
        run_cycle(32'h00000001, st);
        check_count("rd_len", 2 * tu, rd_c);
        check_count("rd_wr_len", 0, wr_c);
        check_count("rd_oe_len", 0, oe_c);
        rd_reg(OFF_RDATA, v);
        check_word("rdata", 32'h00005AC3, v);
    endtask

    // rows: async, polarity, access units, ready wait, ready enable, strobe units
    task automatic t_ready();
        int tbl [5][6] = '{'{0, 1, 1, 3, 1, 4}, '{0, 0, 3, 0, 1, 3}, '{1, 1, 1, 0, 1, 2},
                           '{1, 0, 2, 4, 1, 5}, '{0, 1, 32, 99, 0, 32}};
        logic [31:0] st, v;
        foreach (tbl[i]) begin
            rdy_pol = tbl[i][1][0];
            wait_u  = tbl[i][3];
            dly     = tbl[i][0] ? 83 : 10;
            hold    = tbl[i][0] ? 110 : 0;
            wr_reg(OFF_CTRL, cfg(1, 0, 0, tbl[i][2], 0, tbl[i][4], tbl[i][1], tbl[i][0]));
            run_cycle(32'h00000001, st);
            check_count("rd_len", tbl[i][5] * tu, rd_c);
            if (tbl[i][0] == 0) check_word("ws", 32'(tbl[i][5] - tbl[i][2]), 32'(st[15:8]));
            rd_reg(OFF_RDATA, v);
            check_word("rdata", 32'h00005AC3, v);
        end
    endtask

    initial begin
        rst_n   = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h00000000;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h00000000;
        rdy_pol = 1'b1;
        wait_u  = 99;
        dly     = 10;
        hold    = 0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_write_read();
        t_ready();
        stop_test();
    end
endmodule // tb_ebr_ctrl
`default_nettype wire
